// ===== core/ucr_top.v
/*
 * Character responder with baud correction, all on pclk.
 * Assumes an APB master, a serial terminal and an async sub-clock.
 */
// Design decisions made here: the placing of the registers and register access over APB.
// What this block does
// [RQ1] error-free 54H answers 4FH 4BH 0DH 0AH
// [RQ2] error-free 74H answers 6FH 6BH 0DH 0AH
// [RQ3] any other error-free character answers 55H 43H 0DH 0AH
// [RQ4] parity error answers 50H 45H 0DH 0AH
// [RQ5] framing error answers 46H 45H 0DH 0AH
// [RQ6] receive overrun answers 4FH 45H 0DH 0AH
// [RQ7] 8 data bits LSB first, even parity, line not inverted
// [RQ8] line rate starts at 9600 bit/s on both channels
// [RQ9] two-bit index picks 9600, 19200 or 38400; 3 unsupported
// [RQ10] interval timer fires every 1000 ms, starting one correction
// [RQ11] oscillator cycles counted over 256 sub-clock periods
// [RQ12] correction: clock on, measure, capture, stop, mask, clock off
// [RQ13] divisor (osc rate / 2*baud - 1) << 8, to both channels
// [RQ14] before load: mask events, stop channels, clear pending
// [RQ15] on start: output high and enabled, channels waiting, events cleared
// [RQ16] correction sets done flag, indicator low until channels restart
// [RQ17] on receive: stop timer, clear its event, mask receive and error
// [RQ18] after queueing a reply, wait for the transmit-done flag
// [RQ19] rearm one-character receive, unmask, restart interval timer
// [RQ20] correction keeps rate deviation near oscillator drift
// [RQ21] cycle count and divisor are 16-bit unsigned
// [RQ22] truncating division; bad result keeps old divisor
`timescale 1ns/1ps
`include "ucr_defs.vh"

module ucr_top #(
  parameter TICK_CYCLES = `UCR_TICK_CYCLES,
  parameter OSC_PRESCALE = `UCR_OSC_PRESCALE
) (
  input wire pclk, // system clock, 200 MHz
  input wire presetn, // async reset, active low
  input wire [7:0] paddr, // apb address
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr, // apb error
  input wire serial_rx_pin, // serial input
  output wire serial_tx_pin, // serial output
  input wire subclock_pin, // 32.768 kHz reference
  output wire indicator_out, // indicator level
  output wire indicator_oe_n, // indicator drive, low drives
  output wire measure_run, // measurement unit running
  output wire measure_clock_gate, // measurement clock enabled
  output wire tick_timer_run // interval timer counting
);

  // ==========================================================
  // state codes
  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_MEAS = 6'b000010;
  localparam [5:0] S_LOAD = 6'b000100;
  localparam [5:0] S_START = 6'b001000;
  localparam [5:0] S_TXW = 6'b010000;
  localparam [5:0] S_REARM = 6'b100000;

  reg [5:0] state_q;
  reg [1:0] baud_sel_q;
  reg [15:0] div_q;
  reg [15:0] count_q;
  reg corr_done_q, tx_done_q, active_q, ind_low_q;
  reg tmr_run_q, tick_pend_q, meas_run_q, meas_gate_q;
  reg rx_mask_q, tx_mask_q;
  reg rx_pend_q, ovr_q;
  reg [2:0] msg_q;
  reg [2:0] rx_msg_q;
  reg tx_go;

  // ==========================================================
  // oscillator enable pulse standing in for the slow clock
  reg [7:0] pre_q;
  wire osc_tick = (pre_q == OSC_PRESCALE[7:0] - 8'h01);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= osc_tick ? 8'h00 : pre_q + 8'h01;
    end
  end

  // ==========================================================
  // pin synchronisers
  reg rx_s1_q, rx_s2_q, rx_s3_q;
  reg sub_s1_q, sub_s2_q, sub_s3_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
      sub_s1_q <= 1'b0;
      sub_s2_q <= 1'b0;
      sub_s3_q <= 1'b0;
    end else begin
      rx_s1_q <= serial_rx_pin;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      sub_s1_q <= subclock_pin;
      sub_s2_q <= sub_s1_q;
      sub_s3_q <= sub_s2_q;
    end
  end
  wire sub_rise = sub_s2_q & ~sub_s3_q;
  wire rx_fall = ~rx_s2_q & rx_s3_q;

  // ==========================================================
  // interval timer, auto reload
  reg [31:0] tmr_q;
  wire tick_hit = tmr_run_q && (tmr_q == TICK_CYCLES - 1);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q <= 32'h0000_0000;
    end else if (!tmr_run_q || tick_hit) begin
      tmr_q <= 32'h0000_0000; // [RQ10]
    end else begin
      tmr_q <= tmr_q + 32'h0000_0001;
    end
  end

  // ==========================================================
  // frequency measurement over 256 sub-clock periods
  reg [15:0] meas_cnt_q;
  reg [8:0] edges_q;
  reg meas_done;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_cnt_q <= 16'h0000;
      edges_q <= 9'h000;
      meas_done <= 1'b0;
    end else begin
      meas_done <= 1'b0;
      if (!meas_run_q || !meas_gate_q) begin
        meas_cnt_q <= 16'h0000;
        edges_q <= 9'h000;
      end else if (edges_q != 9'h000 || sub_rise) begin
        // window opens on the first edge: no partial period
        if (osc_tick && edges_q != 9'h000) begin
          meas_cnt_q <= meas_cnt_q + 16'h0001; // [RQ11] [RQ21]
        end
        if (sub_rise) begin
          if (edges_q == `UCR_MEAS_PERIODS) begin
            meas_done <= 1'b1; // [RQ11]
            edges_q <= 9'h000;
          end else begin
            edges_q <= edges_q + 9'h001;
          end
        end
      end
    end
  end

  // ==========================================================
  // divisor arithmetic, truncating
  reg [31:0] baud_hz;
  always @* begin
    case (baud_sel_q)
      2'd0: baud_hz = `UCR_BAUD_0; // [RQ9]
      2'd1: baud_hz = `UCR_BAUD_1;
      2'd2: baud_hz = `UCR_BAUD_2;
      default: baud_hz = `UCR_BAUD_0; // unsupported index falls back
    endcase
  end
  wire [31:0] osc_hz = (count_q * `UCR_SUB_HZ) >> `UCR_MEAS_SHIFT;
  wire [31:0] quot = osc_hz / {baud_hz[30:0], 1'b0};
  wire div_ok = (quot >= 32'd2) && (quot <= 32'd256); // [RQ22]
  wire [7:0] quot_m1 = quot[7:0] - 8'h01;
  wire [15:0] div_new = {quot_m1, 8'h00}; // [RQ13]

  // ==========================================================
  // receiver: start, 8 data LSB first, even parity, stop
  reg rx_busy_q, rx_run_q;
  reg [8:0] rx_cnt_q;
  reg [3:0] rx_bits_q;
  reg [7:0] rx_sh_q;
  reg rx_par_q;
  reg rx_evt;
  reg [2:0] rx_code;
  wire [7:0] half = div_q[15:8];
  wire [8:0] full = {half, 1'b1};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_busy_q <= 1'b0;
      rx_run_q <= 1'b0;
      rx_cnt_q <= 9'h000;
      rx_bits_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_par_q <= 1'b0;
      rx_evt <= 1'b0;
      rx_code <= `UCR_MSG_UC;
    end else begin
      rx_evt <= 1'b0;
      if (!active_q) begin
        rx_busy_q <= 1'b0;
      end else if (!rx_busy_q) begin
        if (rx_fall) begin
          rx_busy_q <= 1'b1;
          rx_run_q <= 1'b0;
          rx_cnt_q <= 9'h000;
          rx_bits_q <= 4'h0;
          rx_par_q <= 1'b0;
        end
      end else if (osc_tick) begin
        rx_cnt_q <= rx_cnt_q + 9'h001;
        if (!rx_run_q && rx_cnt_q == {1'b0, half}) begin
          // mid start bit: a glitch gone high is dropped
          rx_run_q <= ~rx_s2_q;
          rx_busy_q <= ~rx_s2_q;
          rx_cnt_q <= 9'h000;
        end else if (rx_run_q && rx_cnt_q == full) begin
          rx_cnt_q <= 9'h000;
          rx_bits_q <= rx_bits_q + 4'h1;
          rx_par_q <= rx_par_q ^ rx_s2_q;
          if (rx_bits_q < 4'd8) begin
            rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]}; // [RQ7]
          end
          if (rx_bits_q == 4'd9) begin
            rx_busy_q <= 1'b0;
            rx_evt <= 1'b1;
            if (!rx_s2_q) begin
              rx_code <= `UCR_MSG_FE; // [RQ5]
            end else if (rx_par_q) begin
              rx_code <= `UCR_MSG_PE; // [RQ4] [RQ7]
            end else if (rx_sh_q == `UCR_CH_UP_T) begin
              rx_code <= `UCR_MSG_OK; // [RQ1]
            end else if (rx_sh_q == `UCR_CH_LO_T) begin
              rx_code <= `UCR_MSG_OKL; // [RQ2]
            end else begin
              rx_code <= `UCR_MSG_UC; // [RQ3]
            end
          end
        end
      end
    end
  end

  // ==========================================================
  // message bytes
  function [7:0] msg_byte;
    input [2:0] sel;
    input [1:0] idx;
    begin
      case (idx)
        2'd0: begin
          case (sel)
            `UCR_MSG_OK: msg_byte = 8'h4F;
            `UCR_MSG_OKL: msg_byte = 8'h6F;
            `UCR_MSG_PE: msg_byte = 8'h50;
            `UCR_MSG_FE: msg_byte = 8'h46;
            `UCR_MSG_OE: msg_byte = 8'h4F;
            default: msg_byte = 8'h55;
          endcase
        end
        2'd1: begin
          case (sel)
            `UCR_MSG_OK: msg_byte = 8'h4B;
            `UCR_MSG_OKL: msg_byte = 8'h6B;
            `UCR_MSG_UC: msg_byte = 8'h43;
            default: msg_byte = 8'h45;
          endcase
        end
        2'd2: msg_byte = `UCR_CR;
        default: msg_byte = `UCR_LF;
      endcase
    end
  endfunction

  // ==========================================================
  // transmitter: four frames back to back
  reg tx_busy_q;
  reg [1:0] tx_idx_q;
  reg [10:0] tx_sh_q;
  reg [3:0] tx_bits_q;
  reg [8:0] tx_cnt_q;
  reg tx_level_q;
  wire [7:0] tx_byte = msg_byte(msg_q, tx_idx_q);
  wire [7:0] nx_byte = msg_byte(msg_q, tx_idx_q + 2'd1);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy_q <= 1'b0;
      tx_idx_q <= 2'd0;
      tx_sh_q <= 11'h7FF;
      tx_bits_q <= 4'h0;
      tx_cnt_q <= 9'h000;
      tx_level_q <= 1'b1;
    end else if (!active_q) begin
      tx_busy_q <= 1'b0;
      tx_level_q <= 1'b1; // [RQ15]
    end else if (tx_go) begin
      tx_busy_q <= 1'b1;
      tx_idx_q <= 2'd0;
      tx_sh_q <= {1'b1, ^msg_byte(msg_q, 2'd0), msg_byte(msg_q, 2'd0), 1'b0};
      tx_bits_q <= 4'h0;
      tx_cnt_q <= 9'h000;
    end else if (tx_busy_q && osc_tick) begin
      tx_level_q <= tx_sh_q[0]; // [RQ7]
      tx_cnt_q <= tx_cnt_q + 9'h001;
      if (tx_cnt_q == full) begin
        tx_cnt_q <= 9'h000;
        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        tx_bits_q <= tx_bits_q + 4'h1;
        if (tx_bits_q == 4'd10) begin
          tx_bits_q <= 4'h0;
          tx_idx_q <= tx_idx_q + 2'd1;
          tx_sh_q <= {1'b1, ^nx_byte, nx_byte, 1'b0};
          tx_busy_q <= (tx_idx_q != 2'd3);
        end
      end
    end else if (!tx_busy_q) begin
      tx_level_q <= 1'b1;
    end
  end
  wire tx_evt = tx_busy_q && osc_tick && tx_cnt_q == full && tx_bits_q == 4'd10
                && tx_idx_q == 2'd3;
  assign serial_tx_pin = tx_level_q;

  // ==========================================================
  // apb slave: zero wait states, read data captured in the setup cycle
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire mapped = (paddr == `UCR_REG_CTRL) || (paddr == `UCR_REG_STATUS) ||
                (paddr == `UCR_REG_COUNT) || (paddr == `UCR_REG_DIV);
  wire wr_ctrl = access && pwrite && paddr == `UCR_REG_CTRL;
  wire clr_corr = access && pwrite && paddr == `UCR_REG_STATUS &&
                  pwdata[`UCR_ST_CORR_DONE];
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `UCR_REG_CTRL: prdata <= {30'h0, baud_sel_q};
        `UCR_REG_STATUS: prdata <= {18'h0, state_q, 5'h0, active_q, tx_done_q, corr_done_q};
        `UCR_REG_COUNT: prdata <= {16'h0, count_q};
        `UCR_REG_DIV: prdata <= {16'h0, div_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_sel_q <= 2'd0; // [RQ8]
    end else if (wr_ctrl) begin
      baud_sel_q <= pwdata[`UCR_CTRL_BAUD_MSB:`UCR_CTRL_BAUD_LSB]; // [RQ9]
    end
  end

  // ==========================================================
  // receive pending and overrun; a new arrival beats a clear
  wire take_rx = (state_q == S_IDLE) && rx_pend_q && !rx_mask_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_pend_q <= 1'b0;
      ovr_q <= 1'b0;
      rx_msg_q <= `UCR_MSG_UC;
    end else if (rx_evt) begin
      rx_pend_q <= 1'b1;
      rx_msg_q <= rx_code;
      ovr_q <= rx_pend_q && !take_rx; // [RQ6]
    end else if (take_rx || state_q == S_LOAD || state_q == S_START) begin
      rx_pend_q <= 1'b0; // [RQ14] [RQ15]
      ovr_q <= 1'b0;
    end
  end

  // ==========================================================
  // sequencer: correction and replies
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_START;
      div_q <= `UCR_DIV_RESET; // [RQ8]
      count_q <= 16'h0000;
      corr_done_q <= 1'b0;
      tx_done_q <= 1'b0;
      active_q <= 1'b0;
      ind_low_q <= 1'b0;
      tmr_run_q <= 1'b0;
      tick_pend_q <= 1'b0;
      meas_run_q <= 1'b0;
      meas_gate_q <= 1'b0;
      rx_mask_q <= 1'b1;
      tx_mask_q <= 1'b1;
      msg_q <= `UCR_MSG_UC;
      tx_go <= 1'b0;
    end else begin
      tx_go <= 1'b0;
      if (tick_hit) begin
        tick_pend_q <= 1'b1;
      end
      if (tx_evt && !tx_mask_q) begin
        tx_done_q <= 1'b1; // [RQ18]
      end
      if (clr_corr && !(state_q == S_IDLE && tick_pend_q)) begin
        corr_done_q <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          if (take_rx) begin
            tmr_run_q <= 1'b0; // [RQ17]
            tick_pend_q <= 1'b0;
            rx_mask_q <= 1'b1;
            msg_q <= ovr_q ? `UCR_MSG_OE : rx_msg_q; // [RQ6]
            tx_done_q <= 1'b0;
            tx_go <= 1'b1;
            state_q <= S_TXW;
          end else if (tick_pend_q) begin
            tick_pend_q <= 1'b0; // [RQ10]
            ind_low_q <= 1'b1; // [RQ16]
            corr_done_q <= 1'b1;
            meas_gate_q <= 1'b1; // [RQ12]
            meas_run_q <= 1'b1;
            state_q <= S_MEAS;
          end
        end
        S_MEAS: begin
          if (meas_done) begin
            count_q <= meas_cnt_q; // [RQ12] [RQ21]
            meas_run_q <= 1'b0;
            meas_gate_q <= 1'b0;
            tx_mask_q <= 1'b1; // [RQ14]
            rx_mask_q <= 1'b1;
            active_q <= 1'b0;
            state_q <= S_LOAD;
          end
        end
        S_LOAD: begin
          // drift is tracked by a fresh count each period
          if (div_ok) begin
            div_q <= div_new; // [RQ13] [RQ20] [RQ22]
          end
          state_q <= S_START;
        end
        S_START: begin
          active_q <= 1'b1; // [RQ15]
          tx_mask_q <= 1'b0;
          rx_mask_q <= 1'b0;
          tmr_run_q <= 1'b1;
          ind_low_q <= 1'b0; // [RQ16]
          state_q <= S_IDLE;
        end
        S_TXW: begin
          if (tx_done_q) begin
            state_q <= S_REARM; // [RQ18]
          end
        end
        S_REARM: begin
          rx_mask_q <= 1'b0; // [RQ19]
          tick_pend_q <= 1'b0;
          tmr_run_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // pin and status outputs
  assign indicator_out = 1'b0;
  assign indicator_oe_n = ~ind_low_q; // [RQ16]
  assign measure_run = meas_run_q;
  assign measure_clock_gate = meas_gate_q;
  assign tick_timer_run = tmr_run_q;

endmodule

// ===== core/ucr_defs.vh
/*
 * Constants of the character responder: offsets, fields, resets,
 * messages and timing. Assumes a 200 MHz clock.
 */
`ifndef UCR_DEFS_VH
`define UCR_DEFS_VH

// ==========================================================
// clock and timing
`define UCR_CLK_MHZ 200
`define UCR_TICK_MS 1000
`define UCR_TICK_CYCLES (`UCR_TICK_MS * `UCR_CLK_MHZ * 1000)
`define UCR_OSC_PRESCALE 50
`define UCR_SUB_HZ 32768
`define UCR_MEAS_SHIFT 8
`define UCR_MEAS_PERIODS 9'h100

// ==========================================================
// register map (byte addresses)
`define UCR_REG_CTRL 8'h00
`define UCR_REG_STATUS 8'h04
`define UCR_REG_COUNT 8'h08
`define UCR_REG_DIV 8'h0C
`define UCR_CTRL_BAUD_LSB 0
`define UCR_CTRL_BAUD_MSB 1
`define UCR_ST_CORR_DONE 0
`define UCR_ST_TX_DONE 1
`define UCR_ST_ACTIVE 2
`define UCR_ST_STATE_LSB 8
`define UCR_DIV_RESET 16'hCF00

// ==========================================================
// line rates
`define UCR_BAUD_0 32'h0000_2580
`define UCR_BAUD_1 32'h0000_4B00
`define UCR_BAUD_2 32'h0000_9600

// ==========================================================
// characters and message selects
`define UCR_CH_UP_T 8'h54
`define UCR_CH_LO_T 8'h74
`define UCR_CR 8'h0D
`define UCR_LF 8'h0A
`define UCR_MSG_OK 3'h0
`define UCR_MSG_OKL 3'h1
`define UCR_MSG_UC 3'h2
`define UCR_MSG_PE 3'h3
`define UCR_MSG_FE 3'h4
`define UCR_MSG_OE 3'h5

`endif

// ===== tb/ucr_top_monitor.sv
/*
 * Checker for ucr_top, top ports only.
 * Assumes one pclk domain, presetn async active low.
 */
`timescale 1ns/1ps
module ucr_top_monitor #(
  parameter TICK_CYCLES = 200000000
) (
  input wire pclk, // clock
  input wire presetn, // reset, active low
  input wire serial_tx_pin, // serial output
  input wire subclock_pin, // reference clock
  input wire indicator_out, // indicator level
  input wire indicator_oe_n, // indicator drive, low drives
  input wire measure_run, // measuring
  input wire measure_clock_gate, // measure clock on
  input wire tick_timer_run // timer counting
);
  reg [31:0] tick_cnt_q;
  reg [9:0] edge_cnt_q;
  reg sub_q;
  reg oe_q;
  wire corr_start;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // helper counters
  // one edge late, so the count is read before it clears
  assign corr_start = oe_q & ~indicator_oe_n;
  // timer age and raw reference edges per window
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0;
      edge_cnt_q <= 10'h0;
      sub_q <= 1'b0;
      oe_q <= 1'b1;
    end else begin
      sub_q <= subclock_pin;
      oe_q <= indicator_oe_n;
      if (!tick_timer_run || corr_start) begin
        tick_cnt_q <= 32'h0;
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h1;
      end
      if (!measure_run) begin
        edge_cnt_q <= 10'h0;
      end else if (subclock_pin && !sub_q) begin
        edge_cnt_q <= edge_cnt_q + 10'h1;
      end
    end
  end

  // ==========================================================
  // assertions
  AST_GATE_HOLDS: assert property (measure_run |-> measure_clock_gate)
    else $error("run without clock");
  AST_STOP_THEN_GATE: assert property ($fell(measure_clock_gate) |-> !measure_run)
    else $error("clock gated while running");
  AST_WINDOW_EDGES: assert property ($fell(measure_run) |->
    edge_cnt_q >= 10'h0FE && edge_cnt_q <= 10'h102)
    else $error("window not 256 periods");
  AST_MEAS_SPAN: assert property ($rose(measure_run) |=> measure_run [*8])
    else $error("window cut short");
  AST_IND_IN_MEAS: assert property (measure_run |-> !indicator_oe_n)
    else $error("indicator off in measurement");
  AST_IND_LEVEL: assert property (!indicator_oe_n |-> !indicator_out)
    else $error("indicator driven but not low");
  AST_GATE_OFF_AFTER: assert property (measure_clock_gate |-> !indicator_oe_n)
    else $error("indicator off with clock on");
  AST_TX_IDLE_CORR: assert property (!indicator_oe_n |-> serial_tx_pin)
    else $error("serial active in correction");
  AST_TIMER_OFF_REPLY: assert property (!serial_tx_pin |-> !tick_timer_run)
    else $error("timer running in reply");
  AST_TICK_PERIOD: assert property ($fell(indicator_oe_n) |->
    tick_cnt_q >= TICK_CYCLES - 8 && tick_cnt_q <= TICK_CYCLES + 8)
    else $error("correction interval wrong");
  AST_RESET_IDLE: assert property ($rose(presetn) |-> serial_tx_pin && indicator_oe_n)
    else $error("outputs not idle after reset");

  COV_MEAS: cover property ($fell(measure_run));
  COV_REPLY: cover property ($fell(serial_tx_pin));
  COV_RESTART: cover property ($rose(indicator_oe_n));
endmodule

bind ucr_top ucr_top_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_monitor (
  .pclk(pclk), .presetn(presetn), .serial_tx_pin(serial_tx_pin),
  .subclock_pin(subclock_pin), .indicator_out(indicator_out),
  .indicator_oe_n(indicator_oe_n), .measure_run(measure_run),
  .measure_clock_gate(measure_clock_gate), .tick_timer_run(tick_timer_run));

// ===== tb/ucr_terminal.sv
/*
 * Remote terminal model: sends frames, collects and checks replies.
 * Assumes bit_cycles is the device bit period in pclk.
 */
`timescale 1ns/1ps
module ucr_terminal (
  input wire pclk, // bench clock
  input wire [15:0] bit_cycles, // bit period in pclk cycles
  input wire tx_line, // device serial output
  output reg rx_line // device serial input
);
  logic [7:0] got_q[$];
  logic [7:0] rbyte;
  integer frame_errs;
  integer k;

  // line idles high
  initial begin
    rx_line = 1'b1;
    frame_errs = 0;
  end

  // start, 8 data lsb first, even parity, stop, idle; faults on request
  task automatic send_frame(input logic [7:0] data, input logic bad_par, input logic bad_stop);
    logic [11:0] bits;
    integer i;
    bits = {1'b1, ~bad_stop, (^data) ^ bad_par, data, 1'b0};
    for (i = 0; i < 12; i++) begin
      @(posedge pclk);
      rx_line <= bits[i];
      repeat (bit_cycles - 1) @(posedge pclk);
    end
  endtask

  // reply receiver, mid-bit sampling; short glitches ignored
  always begin
    @(negedge tx_line);
    repeat (bit_cycles / 2) @(posedge pclk);
    if (tx_line === 1'b0) begin
      for (k = 0; k < 8; k++) begin
        repeat (bit_cycles) @(posedge pclk);
        rbyte[k] = tx_line;
      end
      repeat (bit_cycles) @(posedge pclk);
      if (tx_line !== ^rbyte) frame_errs++;
      repeat (bit_cycles) @(posedge pclk);
      if (tx_line !== 1'b1) frame_errs++;
      got_q.push_back(rbyte);
    end
  end
endmodule

// ===== tb/uart_responder_baud_correction_test.sv
/*
 * Bench for ucr_top: registers, corrections, replies, overrun.
 * Assumes ucr_defs.vh on the include path; tick interval shortened.
 */
`timescale 1ns/1ps
`include "ucr_defs.vh"
module uart_responder_baud_correction_test;
  localparam int TICK = 10000;
  localparam int OSC_PRE = 2;
  localparam int NOM_COUNT = 20 * 256 / OSC_PRE;
  reg pclk, presetn, psel, penable, pwrite, subclock_pin;
  reg [7:0] paddr;
  reg [31:0] pwdata;
  reg [15:0] bit_cycles;
  wire [31:0] prdata;
  wire pready, pslverr, serial_rx_pin, serial_tx_pin, indicator_out, indicator_oe_n;
  wire measure_run, measure_clock_gate, tick_timer_run;
  integer bad_count, tests_run, cycles;
  logic [31:0] rd;
  logic err;

  ucr_top #(.TICK_CYCLES(TICK), .OSC_PRESCALE(OSC_PRE)) DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
    .subclock_pin(subclock_pin), .indicator_out(indicator_out),
    .indicator_oe_n(indicator_oe_n), .measure_run(measure_run),
    .measure_clock_gate(measure_clock_gate), .tick_timer_run(tick_timer_run));
  ucr_terminal term (.pclk(pclk), .bit_cycles(bit_cycles), .tx_line(serial_tx_pin),
    .rx_line(serial_rx_pin));

  // ==========================================================
  // 200 MHz pclk; reference of 20 pclk periods, edges on pclk falling edges
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    subclock_pin = 1'b0;
    forever #50 subclock_pin = ~subclock_pin;
  end

  // ==========================================================
  // shared tasks
  task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; rd and err taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_oe(input logic lvl, input integer lim);
    integer n = 0;
    while (indicator_oe_n !== lvl && n < lim) begin
      @(posedge pclk);
      n++;
    end
    check32("indicator drive", {31'h0, lvl}, {31'h0, indicator_oe_n});
  endtask

  task automatic expect_reply(input logic [31:0] msg);
    integer n, i;
    logic [7:0] b;
    n = 0;
    while (term.got_q.size() < 4 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    for (i = 3; i >= 0; i--) begin
      b = 8'hXX;
      if (term.got_q.size() > 0) b = term.got_q.pop_front();
      check32("reply byte", {24'h0, msg[8*i +: 8]}, {24'h0, b});
    end
    check32("reply frame faults", 32'h0, term.frame_errs);
  endtask

  task give_verdict;
    $display("tests run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs;
    apb(1'b0, `UCR_REG_CTRL, 32'h0);
    check32("ctrl reset", 32'h0, rd);
    apb(1'b0, `UCR_REG_STATUS, 32'h0);
    check32("status reset", 32'h0000_0100, rd & 32'h0000_3F01);
    apb(1'b0, `UCR_REG_DIV, 32'h0);
    check32("divisor reset", {16'h0, `UCR_DIV_RESET}, rd);
    apb(1'b0, 8'h10, 32'h0);
    check32("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, `UCR_REG_CTRL, 32'hFFFF_FFFF);
    apb(1'b0, `UCR_REG_CTRL, 32'h0);
    check32("ctrl index", 32'h3, rd);
    apb(1'b1, `UCR_REG_CTRL, 32'h0);
    $display("test registers done");
  endtask

  // one correction: divisor, count and done flag
  task automatic t_correct(input logic [1:0] idx, input integer baud);
    integer q = NOM_COUNT * `UCR_SUB_HZ / 256 / (2 * baud) - 1;
    apb(1'b1, `UCR_REG_CTRL, {30'h0, idx});
    wait_oe(1'b0, 3 * TICK);
    wait_oe(1'b1, 20000);
    apb(1'b0, `UCR_REG_DIV, 32'h0);
    check32("divisor", q << 8, rd);
    apb(1'b0, `UCR_REG_COUNT, 32'h0);
    check32("count in window", 32'h1, {31'h0, rd >= NOM_COUNT - 12 && rd <= NOM_COUNT + 12});
    apb(1'b0, `UCR_REG_STATUS, 32'h0);
    check32("done flag set", 32'h1, {31'h0, rd[0]});
    apb(1'b1, `UCR_REG_STATUS, 32'h1);
    apb(1'b0, `UCR_REG_STATUS, 32'h0);
    check32("done flag cleared", 32'h0, {31'h0, rd[0]});
    bit_cycles = (2 * q + 2) * OSC_PRE;
    $display("test correction %0d done", baud);
  endtask

  task automatic t_char(input logic [7:0] ch, input logic bp, input logic bs,
    input logic [31:0] msg);
    term.send_frame(ch, bp, bs);
    expect_reply(msg);
    $display("test character %h done", ch);
  endtask

  // third character lands while the second still waits
  task automatic t_overrun;
    term.send_frame(8'h41, 1'b0, 1'b0);
    term.send_frame(8'h42, 1'b0, 1'b0);
    term.send_frame(8'h43, 1'b0, 1'b0);
    expect_reply(32'h5543_0D0A);
    expect_reply(32'h4F45_0D0A);
    $display("test overrun done");
  endtask

  // ==========================================================
  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      bad_count++;
      give_verdict;
    end
  end

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bit_cycles = 16'h0340;
    bad_count = 0;
    tests_run = 0;
    cycles = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_regs;
    t_correct(2'h0, `UCR_BAUD_0);
    t_char(`UCR_CH_UP_T, 1'b0, 1'b0, 32'h4F4B_0D0A);
    t_char(`UCR_CH_LO_T, 1'b0, 1'b0, 32'h6F6B_0D0A);
    t_char(8'h5A, 1'b0, 1'b0, 32'h5543_0D0A);
    t_char(`UCR_CH_UP_T, 1'b1, 1'b0, 32'h5045_0D0A);
    t_char(`UCR_CH_LO_T, 1'b0, 1'b1, 32'h4645_0D0A);
    t_overrun;
    t_correct(2'h1, `UCR_BAUD_1);
    t_char(`UCR_CH_UP_T, 1'b0, 1'b0, 32'h4F4B_0D0A);
    t_correct(2'h2, `UCR_BAUD_2);
    t_char(8'h00, 1'b0, 1'b0, 32'h5543_0D0A);
    give_verdict;
  end
endmodule
